/* include/link_sync_pkg.sv */
// Constants, register map and state type for the receive link synchroniser
package link_sync_pkg;
    // Control characters (data octet value with the control flag set)
    localparam logic [7:0] CHAR_COMMA = 8'hBC;
    localparam logic [7:0] CHAR_MF_START = 8'h1C;
    localparam logic [7:0] CHAR_CFG_START = 8'h9C;
    localparam logic [7:0] CHAR_ALIGN = 8'h7C;

    // Register map, byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CFG0 = 8'h08;
    localparam logic [7:0] ADDR_CFG1 = 8'h0C;
    localparam logic [7:0] ADDR_CFG2 = 8'h10;
    localparam logic [7:0] ADDR_CFG3 = 8'h14;

    // Control fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam logic CTRL_ENABLE_RESET = 1'b1;

    // Status fields
    localparam int STAT_SYNC_BIT = 0;
    localparam int STAT_CGS_BIT = 1;
    localparam int STAT_FS_BIT = 2;
    localparam int STAT_ALIGNED_BIT = 3;
    localparam int STAT_CODE_ERR_BIT = 4;
    localparam int STAT_DISP_ERR_BIT = 5;
    localparam int STAT_ILAS_ERR_BIT = 6;

    // Link framing
    localparam int OCTETS_PER_WORD = 4;
    localparam int ILAS_MULTIFRAMES = 4;
    localparam int CFG_OCTETS = 14;
    localparam int CFG_WORDS = 4;

    // Clocks, in MHz
    localparam real DEVICE_CLOCK_MHZ = 153.6;
    localparam real MGMT_CLOCK_MHZ = 100.0;

    typedef enum logic [2:0] {
        ST_CGS_SEARCH,
        ST_CGS_VERIFY,
        ST_FS_WAIT,
        ST_ILAS,
        ST_USER
    } sync_state_e;
endpackage

/* logic/link_sync_rx.sv */
// Receive data link layer: code group sync, frame sync and lane alignment
`timescale 1ns/100ps

// Notes on behaviour
// - Each lane delivers one 32-bit word of four octets; lanes concatenate.
// - Sync request is asserted at start-up; transmitter then sends only commas.
// - Sync request releases only after four successive clean commas.
// - Full code group sync after four more clean characters follow.
// - Per-octet code and disparity error flags for every lane.
// - Per-octet control flag for comma, start, config-start and align characters.
// - Per-lane valid follows the decoder's valid for that lane.
// - Frame sync enters its data state on the first non-comma character if it is a multiframe start.
// - Alignment sequence opens with multiframe start right after commas.
// - Every alignment multiframe ends with the align character.
// - Second alignment multiframe opens with start then config-start.
// - Fourteen config octets of multiframe two land in four readable words.
// - Link error output stays low while clean, rises on any error once code group sync is reached.
// - Lanes-aligned rises on the last align character of the sequence.
// - Four-bit start-of-multiframe marks multiframe octet positions in user data.
// - Registers run on the link clock, not on a separate 100 MHz management clock.
module link_sync_rx #(
    parameter int LANES = 2,
    parameter int MF_OCTETS = 32
) (
    input wire logic clock, // Link clock, registers share it
    input wire logic resetn, // Synchronous reset, active low
    input wire logic [LANES*32-1:0] pcs_data, // Decoded octets from the lane decoders
    input wire logic [LANES*4-1:0] pcs_kchar, // Decoder control-character marks
    input wire logic [LANES*4-1:0] pcs_code_err, // Decoder not-in-table marks
    input wire logic [LANES*4-1:0] pcs_disp_err, // Decoder disparity marks
    input wire logic [LANES-1:0] pcs_valid, // Decoder word valid per lane
    output logic [LANES*32-1:0] lane_octet_bus, // Registered lane words
    output logic [LANES-1:0] lane_word_valid, // Registered per-lane valid
    output logic [LANES*4-1:0] control_char_flags, // Per-octet control flag
    output logic [LANES*4-1:0] code_error_flags, // Per-octet not-in-table flag
    output logic [LANES*4-1:0] disparity_error_flags, // Per-octet disparity flag
    output logic sync_request_n, // Sync request, active low
    output logic frame_sync_data_state, // Frame sync in data state
    output logic lanes_aligned, // Lanes aligned
    output logic [3:0] somf, // Start of multiframe per octet
    output logic link_error_irq, // Any link error seen
    input wire logic [7:0] reg_addr, // Register byte address
    input wire logic [31:0] reg_wdata, // Register write data
    input wire logic reg_write, // Write strobe
    input wire logic reg_read, // Read strobe
    output logic [31:0] reg_rdata // Read data, cycle after the strobe
);
    localparam int POS_W = $clog2(MF_OCTETS);
    localparam logic [POS_W-1:0] LAST_POS = POS_W'(MF_OCTETS - link_sync_pkg::OCTETS_PER_WORD);
    localparam logic [POS_W-1:0] STEP = POS_W'(link_sync_pkg::OCTETS_PER_WORD);
    localparam logic [1:0] MF_LAST = 2'(link_sync_pkg::ILAS_MULTIFRAMES - 1);

    function automatic logic is_ctrl(input logic [7:0] octet, input logic k);
        is_ctrl = k && (octet == link_sync_pkg::CHAR_COMMA ||
            octet == link_sync_pkg::CHAR_MF_START ||
            octet == link_sync_pkg::CHAR_CFG_START ||
            octet == link_sync_pkg::CHAR_ALIGN);
    endfunction

    function automatic logic is_char(input logic [7:0] octet, input logic k,
        input logic [7:0] code);
        is_char = k && (octet == code);
    endfunction

    link_sync_pkg::sync_state_e state;
    link_sync_pkg::sync_state_e next_state;
    logic [POS_W-1:0] oct_pos;
    logic [1:0] mf_idx;
    logic [31:0] cap [link_sync_pkg::CFG_WORDS];
    logic ctrl_enable;
    logic code_err;
    logic disp_err;
    logic ilas_err;

    // Per-lane word classification
    logic [LANES-1:0] lane_comma;
    logic [LANES-1:0] lane_clean;
    logic [LANES-1:0] lane_mf_start;
    logic [LANES-1:0] lane_cfg_start;
    logic [LANES-1:0] lane_align;
    logic [LANES*4-1:0] ctrl_now;
    logic [LANES*4-1:0] valid_mask;

    for (genvar l = 0; l < LANES; l++)
    begin : g_lane
        wire logic [31:0] w = pcs_data[l*32 +: 32];
        wire logic [3:0] k = pcs_kchar[l*4 +: 4];
        assign valid_mask[l*4 +: 4] = {4{pcs_valid[l]}};
        assign lane_clean[l] = pcs_valid[l] && pcs_code_err[l*4 +: 4] == 4'h0 &&
            pcs_disp_err[l*4 +: 4] == 4'h0;
        assign lane_comma[l] = lane_clean[l] && k == 4'hF &&
            w == {4{link_sync_pkg::CHAR_COMMA}};
        assign lane_mf_start[l] = is_char(w[7:0], k[0], link_sync_pkg::CHAR_MF_START);
        assign lane_cfg_start[l] = is_char(w[15:8], k[1], link_sync_pkg::CHAR_CFG_START);
        assign lane_align[l] = is_char(w[31:24], k[3], link_sync_pkg::CHAR_ALIGN);
        for (genvar o = 0; o < 4; o++)
        begin : g_oct
            assign ctrl_now[l*4+o] = is_ctrl(w[o*8 +: 8], k[o]);
        end
    end

    wire logic word_comma = &lane_comma;
    wire logic word_clean = &lane_clean;
    wire logic word_valid = &pcs_valid;
    wire logic mf_first = oct_pos == '0;
    wire logic mf_last = oct_pos == LAST_POS;
    wire logic ilas_head_ok = mf_idx == 2'd1 ? &(lane_mf_start & lane_cfg_start) :
        &lane_mf_start;
    wire logic ilas_bad = state == link_sync_pkg::ST_ILAS && word_valid &&
        ((mf_first && !ilas_head_ok) || (mf_last && !(&lane_align)));
    wire logic ilas_done = state == link_sync_pkg::ST_ILAS && word_valid && mf_last &&
        &lane_align && mf_idx == MF_LAST;
    wire logic synced = state != link_sync_pkg::ST_CGS_SEARCH &&
        state != link_sync_pkg::ST_CGS_VERIFY;
    wire logic code_hit = synced && |(pcs_code_err & valid_mask);
    wire logic disp_hit = synced && |(pcs_disp_err & valid_mask);
    wire logic cap_hit = state == link_sync_pkg::ST_ILAS && word_valid && mf_idx == 2'd1 &&
        int'(oct_pos) < link_sync_pkg::CFG_WORDS * link_sync_pkg::OCTETS_PER_WORD;
    wire logic [1:0] cap_sel = 2'(oct_pos >> 2);
    wire logic clear_req = reg_write && reg_addr == link_sync_pkg::ADDR_CTRL &&
        reg_wdata[link_sync_pkg::CTRL_CLEAR_BIT];
    wire logic err_event = code_hit || disp_hit || ilas_bad;
    wire logic [POS_W-1:0] next_pos = mf_last ? '0 : oct_pos + STEP;

    always_comb
    begin
        next_state = state;
        case (state)
            link_sync_pkg::ST_CGS_SEARCH:
                if (word_comma)
                    next_state = link_sync_pkg::ST_CGS_VERIFY;
            link_sync_pkg::ST_CGS_VERIFY:
                if (word_valid)
                    next_state = word_clean ? link_sync_pkg::ST_FS_WAIT :
                        link_sync_pkg::ST_CGS_SEARCH;
            link_sync_pkg::ST_FS_WAIT:
                if (word_valid && !word_comma)
                    next_state = &lane_mf_start ? link_sync_pkg::ST_ILAS :
                        link_sync_pkg::ST_CGS_SEARCH;
            link_sync_pkg::ST_ILAS:
                if (ilas_bad)
                    next_state = link_sync_pkg::ST_CGS_SEARCH;
                else if (ilas_done)
                    next_state = link_sync_pkg::ST_USER;
            link_sync_pkg::ST_USER:
                next_state = link_sync_pkg::ST_USER;
            default:
                next_state = link_sync_pkg::ST_CGS_SEARCH;
        endcase
        if (!ctrl_enable)
            next_state = link_sync_pkg::ST_CGS_SEARCH;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            state <= link_sync_pkg::ST_CGS_SEARCH;
        else
            state <= next_state;
    end

    // The first non-comma word already sits at multiframe octet 0
    always_ff @(posedge clock)
    begin
        if (!resetn || next_state == link_sync_pkg::ST_CGS_SEARCH)
        begin
            oct_pos <= '0;
            mf_idx <= 2'd0;
        end
        else if (state == link_sync_pkg::ST_FS_WAIT && next_state == link_sync_pkg::ST_ILAS)
        begin
            oct_pos <= STEP;
            mf_idx <= 2'd0;
        end
        else if (word_valid && (state == link_sync_pkg::ST_ILAS ||
            state == link_sync_pkg::ST_USER))
        begin
            oct_pos <= next_pos;
            if (mf_last)
                mf_idx <= mf_idx + 2'd1;
        end
    end

    // Lane 0 carries the configuration octets used for the readable copy
    always_ff @(posedge clock)
    begin
        if (!resetn)
            cap <= '{default: 32'h0};
        else if (cap_hit)
            cap[cap_sel] <= pcs_data[31:0];
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            lane_octet_bus <= '0;
            lane_word_valid <= '0;
            control_char_flags <= '0;
            code_error_flags <= '0;
            disparity_error_flags <= '0;
        end
        else
        begin
            lane_octet_bus <= pcs_data;
            lane_word_valid <= pcs_valid;
            control_char_flags <= ctrl_now & valid_mask;
            code_error_flags <= pcs_code_err & valid_mask;
            disparity_error_flags <= pcs_disp_err & valid_mask;
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            code_err <= 1'b0;
            disp_err <= 1'b0;
            ilas_err <= 1'b0;
        end
        else
        begin
            code_err <= code_hit || (code_err && !clear_req);
            disp_err <= disp_hit || (disp_err && !clear_req);
            ilas_err <= ilas_bad || (ilas_err && !clear_req);
        end
    end

    assign link_error_irq = code_err || disp_err || ilas_err;
    assign sync_request_n = state != link_sync_pkg::ST_CGS_SEARCH;
    assign frame_sync_data_state = state == link_sync_pkg::ST_ILAS ||
        state == link_sync_pkg::ST_USER;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            lanes_aligned <= 1'b0;
            somf <= 4'h0;
        end
        else
        begin
            lanes_aligned <= next_state == link_sync_pkg::ST_USER;
            for (int i = 0; i < 4; i++)
                somf[i] <= state == link_sync_pkg::ST_USER && word_valid &&
                    (oct_pos == '0 ? i == 0 : 32'(oct_pos) + i == MF_OCTETS);
        end
    end

    // Register slave
    wire logic [31:0] cfg0 = {cap[1][15:0], cap[0][31:16]};
    wire logic [31:0] cfg1 = {cap[2][15:0], cap[1][31:16]};
    wire logic [31:0] cfg2 = {cap[3][15:0], cap[2][31:16]};
    wire logic [31:0] cfg3 = {16'h0000, cap[3][31:16]};
    logic [31:0] status_word;
    logic [31:0] read_mux;

    always_comb
    begin
        status_word = 32'h0;
        status_word[link_sync_pkg::STAT_SYNC_BIT] = sync_request_n;
        status_word[link_sync_pkg::STAT_CGS_BIT] = synced;
        status_word[link_sync_pkg::STAT_FS_BIT] = frame_sync_data_state;
        status_word[link_sync_pkg::STAT_ALIGNED_BIT] = lanes_aligned;
        status_word[link_sync_pkg::STAT_CODE_ERR_BIT] = code_err;
        status_word[link_sync_pkg::STAT_DISP_ERR_BIT] = disp_err;
        status_word[link_sync_pkg::STAT_ILAS_ERR_BIT] = ilas_err;
        case (reg_addr)
            link_sync_pkg::ADDR_CTRL: read_mux = {31'h0, ctrl_enable};
            link_sync_pkg::ADDR_STATUS: read_mux = status_word;
            link_sync_pkg::ADDR_CFG0: read_mux = cfg0;
            link_sync_pkg::ADDR_CFG1: read_mux = cfg1;
            link_sync_pkg::ADDR_CFG2: read_mux = cfg2;
            link_sync_pkg::ADDR_CFG3: read_mux = cfg3;
            default: read_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            ctrl_enable <= link_sync_pkg::CTRL_ENABLE_RESET;
            reg_rdata <= 32'h0;
        end
        else
        begin
            if (reg_write && reg_addr == link_sync_pkg::ADDR_CTRL)
                ctrl_enable <= reg_wdata[link_sync_pkg::CTRL_ENABLE_BIT];
            reg_rdata <= reg_read ? read_mux : 32'h0;
        end
    end

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_sync_after_commas: assert property ($rose(sync_request_n) |-> $past(word_comma))
        else $error("sync request released without a comma word");
    a_full_cgs_step: assert property (
        state == link_sync_pkg::ST_CGS_VERIFY && word_clean && ctrl_enable
        |=> state == link_sync_pkg::ST_FS_WAIT)
        else $error("clean characters did not complete code group sync");
    a_error_flags_follow: assert property (
        $past(resetn) |-> code_error_flags == $past(pcs_code_err & valid_mask))
        else $error("code error flags do not follow the decoder");
    a_ctrl_flag_match: assert property (
        $past(resetn) |-> control_char_flags == $past(ctrl_now & valid_mask))
        else $error("control flags wrong");
    a_valid_follow: assert property ($past(resetn) |-> lane_word_valid == $past(pcs_valid))
        else $error("lane valid does not follow the decoder");
    a_frame_sync_data_state_entry: assert property (
        state == link_sync_pkg::ST_FS_WAIT && word_valid && !word_comma &&
        &lane_mf_start && ctrl_enable |=> frame_sync_data_state)
        else $error("frame sync missed the first non-comma word");
    a_align_on_last: assert property (
        $rose(lanes_aligned) |-> $past(state == link_sync_pkg::ST_ILAS && mf_last &&
        &lane_align && mf_idx == MF_LAST))
        else $error("lanes aligned without the final align character");
    a_irq_on_error: assert property (
        err_event |=> link_error_irq ##1 (link_error_irq || $past(clear_req)))
        else $error("link error did not raise and hold the error output");
    a_irq_quiet: assert property (!link_error_irq && !err_event |=> !link_error_irq)
        else $error("error output rose with no error");
    a_somf_data_only: assert property (!lanes_aligned |=> somf == 4'h0)
        else $error("multiframe start outside user data");
    a_cfg_capture: assert property (
        cap_hit && cap_sel == 2'd3 |=> cfg3[15:0] == $past(pcs_data[31:16]))
        else $error("config octets not captured");
    a_reset_state: assert property (@(posedge clock) disable iff (1'b0)
        !resetn |=> !sync_request_n && !lanes_aligned && !frame_sync_data_state)
        else $error("reset did not return to comma search");

    c_aligned: cover property ($rose(lanes_aligned));
    c_error: cover property ($rose(link_error_irq));
    c_resync: cover property (ilas_bad);
    c_user_somf: cover property (somf[0]);
endmodule

/* verification/lane_tx_model.sv */
// Behavioural transmitter lanes feeding the receive link synchroniser
`timescale 1ns/100ps
module lane_tx_model #(
    parameter int LANES = 2,
    parameter int MF_OCTETS = 32
) (
    input wire logic clock, // Link clock
    input wire logic resetn, // Active low reset
    input wire logic sync_request_n, // Receiver sync request
    input wire logic hold, // Stall, lanes not valid
    input wire logic inject_code, // Not-in-table mark, lane 0 octet 2
    input wire logic inject_disp, // Disparity mark, lane 0 octet 2
    input wire logic break_align, // Drop align char of multiframe 0
    output logic [LANES*32-1:0] pcs_data, // Decoded words
    output logic [LANES*4-1:0] pcs_kchar, // Control marks
    output logic [LANES*4-1:0] pcs_code_err, // Not-in-table marks
    output logic [LANES*4-1:0] pcs_disp_err, // Disparity marks
    output logic [LANES-1:0] pcs_valid // Word valid per lane
);
    localparam int WORDS = MF_OCTETS / 4;
    logic [15:0] cnt;
    logic [LANES*32-1:0] last_data;

    // Word counter restarts whenever the receiver asks for sync again
    always_ff @(posedge clock)
    begin
        if (!resetn || !sync_request_n)
            cnt <= 16'h0000;
        else if (!hold && cnt != 16'hFFFF)
            cnt <= cnt + 16'h0001;
        if (!hold)
            last_data <= pcs_data;
    end

    always_comb
    begin
        int idx;
        int mf;
        int n;
        logic [7:0] v;
        logic k;
        idx = 0;
        mf = 0;
        n = 0;
        v = 8'h00;
        k = 1'b0;
        pcs_data = '0;
        pcs_kchar = '0;
        pcs_valid = hold ? '0 : '1;
        pcs_code_err = '0;
        pcs_disp_err = '0;
        pcs_code_err[2] = inject_code & ~hold;
        pcs_disp_err[2] = inject_disp & ~hold;
        for (int l = 0; l < LANES; l++)
            for (int o = 0; o < 4; o++)
            begin
                idx = int'(cnt) - 2;
                mf = idx / WORDS;
                n = (idx % WORDS) * 4 + o;
                k = 1'b1;
                if (!sync_request_n || idx < 0)
                    v = link_sync_pkg::CHAR_COMMA;
                else if (idx >= 4 * WORDS)
                    v = {cnt[5:0], 2'(o)};
                else if (n == 0)
                    v = link_sync_pkg::CHAR_MF_START;
                else if (mf == 1 && n == 1)
                    v = link_sync_pkg::CHAR_CFG_START;
                else if (n == MF_OCTETS - 1 && !(break_align && mf == 0))
                    v = link_sync_pkg::CHAR_ALIGN;
                else if (mf == 1 && n < 16)
                    v = 8'h50 + 8'(n - 2);
                else
                    v = 8'h20 + 8'(n);
                if (v != link_sync_pkg::CHAR_COMMA && (idx >= 4 * WORDS || v[7:4] > 4'h1))
                    k = (v == link_sync_pkg::CHAR_ALIGN || v == link_sync_pkg::CHAR_CFG_START)
                        && idx < 4 * WORDS;
                // A stalled lane shows the inverse of its last word, never a stale copy
                pcs_data[l*32+o*8+:8] = hold ? ~last_data[l*32+o*8+:8] : ((l != 0 && !k) ? ~v : v);
                pcs_kchar[l*4+o] = k & ~hold;
            end
    end
endmodule

/* verification/serial_converter_rx_link_sync_bench.sv */
// Self-checking bench for the receive link synchroniser
`timescale 1ns/100ps
module serial_converter_rx_link_sync_bench;
    localparam int LANES = 2;
    localparam int WORDS = 8;
    logic clock, resetn, hold, inject_code, inject_disp, break_align, reg_write, reg_read;
    logic [63:0] pcs_data, lane_octet_bus;
    logic [7:0] pcs_kchar, pcs_code_err, pcs_disp_err, control_char_flags, code_error_flags;
    logic [7:0] disparity_error_flags, reg_addr;
    logic [1:0] pcs_valid, lane_word_valid;
    logic sync_request_n, frame_sync_data_state, lanes_aligned, link_error_irq;
    logic [3:0] somf;
    logic [31:0] reg_wdata, reg_rdata, rd;
    int err_count, checks, t_fs;
    int cycle = 0;

    link_sync_rx #(.LANES(LANES), .MF_OCTETS(WORDS * 4)) uut (.clock(clock), .resetn(resetn),
        .pcs_data(pcs_data), .pcs_kchar(pcs_kchar), .pcs_code_err(pcs_code_err),
        .pcs_disp_err(pcs_disp_err), .pcs_valid(pcs_valid), .lane_octet_bus(lane_octet_bus),
        .lane_word_valid(lane_word_valid), .control_char_flags(control_char_flags),
        .code_error_flags(code_error_flags), .disparity_error_flags(disparity_error_flags),
        .sync_request_n(sync_request_n), .frame_sync_data_state(frame_sync_data_state),
        .lanes_aligned(lanes_aligned), .somf(somf), .link_error_irq(link_error_irq),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata));

    lane_tx_model #(.LANES(LANES), .MF_OCTETS(WORDS * 4)) partner (.clock(clock),
        .resetn(resetn), .sync_request_n(sync_request_n), .hold(hold),
        .inject_code(inject_code), .inject_disp(inject_disp), .break_align(break_align),
        .pcs_data(pcs_data), .pcs_kchar(pcs_kchar), .pcs_code_err(pcs_code_err),
        .pcs_disp_err(pcs_disp_err), .pcs_valid(pcs_valid));

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock)
        cycle <= cycle + 1;

    task automatic final_report();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic pick(input int which);
        case (which)
            0: pick = sync_request_n;
            1: pick = frame_sync_data_state;
            2: pick = lanes_aligned;
            default: pick = link_error_irq;
        endcase
    endfunction

    // Bounded wait on a status output, sampled at the falling edge
    task automatic wait_sig(input int which, input logic level, input int bound);
        int i;
        i = 0;
        @(negedge clock);
        while (pick(which) !== level && i < bound)
        begin
            @(negedge clock);
            i++;
        end
        check(pick(which), level);
        if (pick(which) !== level)
            final_report();
    endtask

    task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clock);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] addr, output logic [31:0] data);
        @(posedge clock);
        reg_addr <= addr;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        data = reg_rdata;
    endtask

    function automatic logic [31:0] cfg_word(input int j);
        cfg_word = 32'h0;
        for (int b = 0; b < 4; b++)
            if (4 * j + b < 14)
                cfg_word[8*b+:8] = 8'h50 + 8'(4 * j + b);
    endfunction

    function automatic logic [63:0] user_word(input logic [5:0] c);
        for (int o = 0; o < 4; o++)
        begin
            user_word[o*8+:8] = {c, 2'(o)};
            user_word[32+o*8+:8] = ~{c, 2'(o)};
        end
    endfunction

    task automatic comma_phase();
        @(negedge clock);
        check(sync_request_n, 1'b0);
        wait_sig(0, 1'b1, 20);
        check(lane_octet_bus, {8{8'hBC}});
        check({control_char_flags, lane_word_valid}, 10'h3FF);
        check({code_error_flags, disparity_error_flags, link_error_irq}, 17'h0);
    endtask

    task automatic alignment();
        wait_sig(1, 1'b1, 20);
        t_fs = cycle;
        check({lane_octet_bus[39:32], lane_octet_bus[7:0]}, 16'h1C1C);
        check({control_char_flags[4], control_char_flags[0]}, 2'b11);
        @(posedge clock);
        hold <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        check(lane_word_valid, 2'b00);
        @(posedge clock);
        hold <= 1'b0;
        wait_sig(2, 1'b1, 100);
        check(cycle - t_fs, 4 * WORDS + 1);
        check({lane_octet_bus[63:56], lane_octet_bus[31:24], link_error_irq}, 17'hF8F8);
        for (int k = 0; k <= WORDS; k++)
        begin
            @(negedge clock);
            check(somf, (k % WORDS == 0) ? 4'h1 : 4'h0);
            if (k == 0)
                check(lane_octet_bus, user_word(6'd34));
        end
        for (int j = 0; j < 4; j++)
        begin
            reg_rd(link_sync_pkg::ADDR_CFG0 + 8'(4 * j), rd);
            check(rd, cfg_word(j));
        end
    endtask

    task automatic registers();
        reg_rd(link_sync_pkg::ADDR_STATUS, rd);
        check(rd, 32'h0000000F);
        reg_rd(8'h40, rd);
        check(rd, 32'h0);
        reg_wr(link_sync_pkg::ADDR_CFG0, 32'hFFFFFFFF);
        reg_rd(link_sync_pkg::ADDR_CFG0, rd);
        check(rd, cfg_word(0));
        reg_rd(link_sync_pkg::ADDR_CTRL, rd);
        check(rd, 32'h1);
    endtask

    task automatic error_flags();
        for (int kind = 0; kind < 2; kind++)
        begin
            check(link_error_irq, 1'b0);
            @(posedge clock);
            inject_code <= (kind == 0);
            inject_disp <= (kind == 1);
            @(posedge clock);
            inject_code <= 1'b0;
            inject_disp <= 1'b0;
            @(negedge clock);
            check({code_error_flags, disparity_error_flags}, kind ? 16'h0004 : 16'h0400);
            wait_sig(3, 1'b1, 3);
            reg_rd(link_sync_pkg::ADDR_STATUS, rd);
            check(rd[5:4], kind ? 2'b10 : 2'b01);
            reg_wr(link_sync_pkg::ADDR_CTRL, 32'h3);
            wait_sig(3, 1'b0, 3);
        end
    endtask

    task automatic broken_alignment();
        reg_wr(link_sync_pkg::ADDR_CTRL, 32'h0);
        break_align <= 1'b1;
        wait_sig(0, 1'b0, 5);
        check(lanes_aligned, 1'b0);
        reg_wr(link_sync_pkg::ADDR_CTRL, 32'h1);
        wait_sig(3, 1'b1, 200);
        check(lanes_aligned, 1'b0);
        reg_rd(link_sync_pkg::ADDR_STATUS, rd);
        check(rd[6], 1'b1);
        break_align <= 1'b0;
        wait_sig(2, 1'b1, 300);
        reg_wr(link_sync_pkg::ADDR_CTRL, 32'h3);
        wait_sig(3, 1'b0, 3);
    endtask

    initial
    begin
        {resetn, hold, inject_code, inject_disp, break_align, reg_write, reg_read} = '0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        {err_count, checks, t_fs} = '0;
        repeat (9) @(posedge clock);
        @(negedge clock);
        check({sync_request_n, frame_sync_data_state, lanes_aligned, link_error_irq}, 4'h0);
        check({somf, reg_rdata}, 36'h0);
        @(posedge clock);
        resetn <= 1'b1;
        comma_phase();
        alignment();
        registers();
        error_flags();
        broken_alignment();
        final_report();
    end
endmodule
